// [verilog/dmacm_top.v]
// Purpose: channel mode control of a four-channel DMA controller
// Assumes: APB slave with no wait states; request pins active low
// Notes:   one request moves one unit; count register sets the total
//
// Contract
// - ack enable bit 30 gates the ack strobe in single address mode; 0 enables.
// - in dual address mode the ack enable bit has no effect.
// - end enable bit 29 gates the active-low end strobe; 0 enables.
// - bit 27 picks low level or falling edge; first request always level.
// - bit 26 delays acceptance of the next request by one cycle.
// - reserved bits 25,24,22-20,18 read zero, writes ignored.
// - bit 23 reads one only while the channel is active.
// - system error flag bit 19 sets on address error or NMI.
// - system error flag exists only in channel 0; others read zero.
// - while the flag is set, transfer enable writes are blocked everywhere.
// - flag clears only by writing zero after reading one; one never sets.
// - errors in module stop mode leave the flag unchanged.
// - bit 31 enables the channel; clearing it stops a running transfer.
// - address error or NMI clears every transfer enable.
`timescale 1ns/1ps
`include "dmacm_defs.vh"
module dmacm_top (
	input  wire                  clock,
	input  wire                  rst,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [31:0]           paddr,
	input  wire [31:0]           pwdata,
	output wire                  pready,
	output wire                  pslverr,
	output wire [31:0]           prdata,
	input  wire                  addrError,
	input  wire                  nmiRequest,
	input  wire                  moduleStop,
	input  wire [`DMACM_NCH-1:0] reqN,
	output wire [`DMACM_NCH-1:0] ackN,
	output wire [`DMACM_NCH-1:0] endN,
	output wire                  irq
);
	localparam ST_IDLE = 3'h1;
	localparam ST_XFER = 3'h2;
	localparam ST_GAP  = 3'h4;
	localparam [31:0] BEAT_LAST_W = `DMACM_XFER_CYC - 1;
	localparam [2:0]  BEAT_LAST   = BEAT_LAST_W[2:0];

	// one decode, shared by the write strobes and error answer; the read mux has its own case
	function mapped;
		input [5:0] a;
		begin
			mapped = (a <= `DMACM_OFS_CNT3) || (a == `DMACM_OFS_STAT) ||
			         (a == `DMACM_OFS_MASK) || (a == `DMACM_OFS_AMODE);
		end
	endfunction

	function [3:0] chanHit;
		input [5:0] a;
		input [5:0] base;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				chanHit[k] = (a == base + k[5:0] * 6'h04);
		end
	endfunction

	wire [5:0]            addr;
	wire                  setup;
	wire                  access;
	wire                  wrAcc;
	wire                  rdAcc;
	wire [3:0]            wrMode;
	wire [3:0]            wrCnt;
	wire [3:0]            rdMode;
	wire                  hwStop;
	wire [`DMACM_NCH-1:0] doneEv;
	wire [`DMACM_NCH*32-1:0] modeRd;
	wire [`DMACM_NCH*16-1:0] cntRd;
	wire [`DMACM_NEV-1:0] statusQ;
	wire [`DMACM_NEV-1:0] maskQ;
	reg  [31:0]           prdata_r;
	reg  [31:0]           rdNxt;
	reg                   system_error_flag_r;
	reg                   errfSeen_r;
	reg  [3:0]            amode_r;

	assign addr    = paddr[5:0];
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign wrAcc   = access & pwrite & mapped(addr) & (paddr[31:6] == 26'h0);
	// an unmapped read aliasing a mode offset must not arm the flag clear
	assign rdAcc   = access & ~pwrite & (paddr[31:6] == 26'h0);
	assign wrMode  = wrAcc ? chanHit(addr, `DMACM_OFS_MODE0) : 4'h0;
	assign wrCnt   = wrAcc ? chanHit(addr, `DMACM_OFS_CNT0) : 4'h0;
	assign rdMode  = rdAcc ? chanHit(addr, `DMACM_OFS_MODE0) : 4'h0;
	assign pready  = 1'b1;
	// unmapped addresses answer with an error and change nothing
	assign pslverr = access & ~(mapped(addr) & (paddr[31:6] == 26'h0));
	assign prdata  = prdata_r;
	assign hwStop  = addrError | nmiRequest;

	// read data captured in the setup phase, so it is a flop in access
	always @* begin
		rdNxt = 32'h0000_0000;
		case (addr)
			6'h00: rdNxt = modeRd[31:0];
			6'h04: rdNxt = modeRd[63:32];
			6'h08: rdNxt = modeRd[95:64];
			6'h0C: rdNxt = modeRd[127:96];
			6'h10: rdNxt = {16'h0000, cntRd[15:0]};
			6'h14: rdNxt = {16'h0000, cntRd[31:16]};
			6'h18: rdNxt = {16'h0000, cntRd[47:32]};
			6'h1C: rdNxt = {16'h0000, cntRd[63:48]};
			`DMACM_OFS_STAT:  rdNxt = {27'h0, statusQ};
			`DMACM_OFS_MASK:  rdNxt = {27'h0, maskQ};
			`DMACM_OFS_AMODE: rdNxt = {28'h0, amode_r};
			default: rdNxt = 32'h0000_0000;
		endcase
		if (paddr[31:6] != 26'h0)
			rdNxt = 32'h0000_0000;
	end

	always @(posedge clock) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
			amode_r  <= `DMACM_AMODE_RST;
		end else begin
			if (setup)
				prdata_r <= rdNxt;
			if (wrAcc && addr == `DMACM_OFS_AMODE)
				amode_r <= pwdata[3:0];
		end
	end

	// system error flag, channel 0 only
	always @(posedge clock) begin
		if (rst) begin
			system_error_flag_r     <= 1'b0;
			errfSeen_r <= 1'b0;
		end else begin
			if (hwStop && !moduleStop) begin
				system_error_flag_r     <= 1'b1;
				errfSeen_r <= 1'b0;
			end else if (wrMode[0] && errfSeen_r && !pwdata[`DMACM_B_SYSTEM_ERROR_FLAG]) begin
				system_error_flag_r     <= 1'b0;
				errfSeen_r <= 1'b0;
			end else if (rdMode[0] && prdata_r[`DMACM_B_SYSTEM_ERROR_FLAG]) begin
				// only a read that returned one arms the clear
				errfSeen_r <= 1'b1;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < `DMACM_NCH; i = i + 1) begin : gCh
			reg  [2:0]  st_r;
			reg  [2:0]  st_nxt;
			reg         te_r;
			reg  [4:0]  cfg_r;
			reg  [15:0] cnt_r;
			reg  [2:0]  beat_r;
			reg         ackOn_r;
			reg         endOn_r;
			reg         ackN_r;
			reg         endN_r;
			wire        reqOk;
			wire        accept;
			wire        beatEnd;
			wire        last;
			wire        errfBit;

			assign accept  = (st_r == ST_IDLE) & te_r & reqOk;
			assign beatEnd = (st_r == ST_XFER) & (beat_r == BEAT_LAST);
			assign last    = (cnt_r == 16'h0001);
			assign doneEv[i] = beatEnd & last & te_r;
			assign errfBit = (i == 0) ? system_error_flag_r : 1'b0;
			// reserved bits are constant zeros here, so writes never land
			assign modeRd[i*32 +: 32] = {te_r, cfg_r, 2'b00,
				(st_r != ST_IDLE), 3'b000, errfBit, 1'b0, 18'h00000};
			assign cntRd[i*16 +: 16] = cnt_r;
			assign ackN[i] = ackN_r;
			assign endN[i] = endN_r;

			dmacm_req_detect dmacm_req_detect_i (
				.clock    (clock),
				.rst      (rst),
				.enable   (te_r),
				.edgeMode (cfg_r[`DMACM_B_REQSEL-26]),
				.reqN     (reqN[i]),
				.accept   (accept),
				.reqOk    (reqOk)
			);

			always @* begin
				st_nxt = st_r;
				case (st_r)
					ST_IDLE: begin
						if (accept)
							st_nxt = ST_XFER;
					end
					ST_XFER: begin
						if (!te_r || hwStop)
							st_nxt = ST_IDLE;
						else if (beatEnd)
							st_nxt = cfg_r[0] ? ST_GAP : ST_IDLE;
					end
					ST_GAP: st_nxt = ST_IDLE;
					default: st_nxt = ST_IDLE;
				endcase
			end

			always @(posedge clock) begin
				if (rst) begin
					st_r    <= ST_IDLE;
					te_r    <= 1'b0;
					cfg_r   <= `DMACM_CFG_RST;
					cnt_r   <= `DMACM_CNT_RST;
					beat_r  <= 3'h0;
					ackOn_r <= 1'b0;
					endOn_r <= 1'b0;
					ackN_r  <= 1'b1;
					endN_r  <= 1'b1;
				end else begin
					st_r <= st_nxt;
					if (hwStop)
						te_r <= 1'b0;
					else if (doneEv[i])
						te_r <= 1'b0;
					else if (wrMode[i] && !system_error_flag_r)
						te_r <= pwdata[`DMACM_B_TE];
					// bit 28 is stored as written; software keeps it zero
					if (wrMode[i])
						cfg_r <= pwdata[`DMACM_B_ACKOE:`DMACM_B_NRD];
					if (wrCnt[i])
						cnt_r <= pwdata[15:0];
					else if (beatEnd && te_r)
						cnt_r <= cnt_r - 16'h0001;
					beat_r <= (st_r == ST_XFER) ? beat_r + 3'h1 : 3'h0;
					// gating latched at acceptance, so a running unit is stable
					if (accept) begin
						ackOn_r <= amode_r[i] & ~cfg_r[4];
						endOn_r <= ~cfg_r[3];
					end
					ackN_r <= ~((st_nxt == ST_XFER) &
						(accept ? (amode_r[i] & ~cfg_r[4]) : ackOn_r));
					endN_r <= ~((st_nxt == ST_XFER) & last &
						(accept ? ~cfg_r[3] : endOn_r));
				end
			end
		end
	endgenerate

	dmacm_irq dmacm_irq_i (
		.clock    (clock),
		.rst      (rst),
		.events   ({system_error_flag_r == 1'b0 && hwStop && !moduleStop, doneEv}),
		.wrStatus (wrAcc && addr == `DMACM_OFS_STAT),
		.wrMask   (wrAcc && addr == `DMACM_OFS_MASK),
		.wdata    (pwdata[`DMACM_NEV-1:0]),
		.status_r (statusQ),
		.mask_r   (maskQ),
		.irq      (irq)
	);
endmodule // dmacm_top

// [verilog/dmacm_defs.vh]
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: 200 MHz clock, 32-bit APB slave, four channels
// Notes:   definitions only
`ifndef DMACM_DEFS_VH
`define DMACM_DEFS_VH

`define DMACM_NCH       4
`define DMACM_CLK_NS    5
`define DMACM_XFER_NS   10
`define DMACM_XFER_CYC  ((`DMACM_XFER_NS + `DMACM_CLK_NS - 1) / `DMACM_CLK_NS)

`define DMACM_OFS_MODE0 6'h00
`define DMACM_OFS_MODE3 6'h0C
`define DMACM_OFS_CNT0  6'h10
`define DMACM_OFS_CNT3  6'h1C
`define DMACM_OFS_STAT  6'h20
`define DMACM_OFS_MASK  6'h24
`define DMACM_OFS_AMODE 6'h28

`define DMACM_B_TE      31
`define DMACM_B_ACKOE   30
`define DMACM_B_ENDOE   29
`define DMACM_B_RSV     28
`define DMACM_B_REQSEL  27
`define DMACM_B_NRD     26
`define DMACM_B_ACT     23
`define DMACM_B_SYSTEM_ERROR_FLAG    19

`define DMACM_CFG_RST   5'h00
`define DMACM_CNT_RST   16'h0000
`define DMACM_AMODE_RST 4'h0
`define DMACM_NEV       5
`define DMACM_EV_ERR    4

`endif

// [verilog/dmacm_req_detect.v]
// Purpose: senses one external request, low level or falling edge
// Assumes: request pin is active low and synchronous to clock
// Notes:   first request after enabling is always taken on level
`timescale 1ns/1ps
module dmacm_req_detect (
	input  wire clock,
	input  wire rst,
	input  wire enable,
	input  wire edgeMode,
	input  wire reqN,
	input  wire accept,
	output wire reqOk
);
	reg  prevR;
	reg  pendR;
	reg  firstR;
	reg  enR;
	wire falling;

	assign falling = prevR & ~reqN;
	// edge mode keeps a caught edge until a transfer consumes it
	assign reqOk = ~edgeMode ? ~reqN : (firstR ? ~reqN : (pendR | falling));

	always @(posedge clock) begin
		if (rst) begin
			prevR  <= 1'b1;
			pendR  <= 1'b0;
			firstR <= 1'b0;
			enR    <= 1'b0;
		end else begin
			prevR  <= reqN;
			enR    <= enable;
			pendR  <= enable & ~accept & (pendR | falling);
			if (!enable || accept)
				firstR <= 1'b0;
			else if (!enR)
				firstR <= 1'b1;
		end
	end
endmodule // dmacm_req_detect

// [verilog/dmacm_irq.v]
// Purpose: sticky event status, mask and one level interrupt
// Assumes: status bits cleared by writing one
// Notes:   a new event beats a clear in the same cycle
`timescale 1ns/1ps
`include "dmacm_defs.vh"
module dmacm_irq (
	input  wire                   clock,
	input  wire                   rst,
	input  wire [`DMACM_NEV-1:0]  events,
	input  wire                   wrStatus,
	input  wire                   wrMask,
	input  wire [`DMACM_NEV-1:0]  wdata,
	output reg  [`DMACM_NEV-1:0]  status_r,
	output reg  [`DMACM_NEV-1:0]  mask_r,
	output wire                   irq
);
	assign irq = |(status_r & mask_r);

	always @(posedge clock) begin
		if (rst) begin
			status_r <= {`DMACM_NEV{1'b0}};
			mask_r   <= {`DMACM_NEV{1'b0}};
		end else begin
			status_r <= events | (status_r & ~(wrStatus ? wdata : {`DMACM_NEV{1'b0}}));
			if (wrMask)
				mask_r <= wdata;
		end
	end
endmodule // dmacm_irq

// [bench/dmacm_props.sv]
// Purpose: port assertions for channel mode control
// Assumes: no-wait APB, strobes active low
// Notes:   only channel 0 strobes are timed
`timescale 1ns/1ps
`include "dmacm_defs.vh"
module dmacm_props (
	input wire                  clock,
	input wire                  rst,
	input wire                  psel,
	input wire                  penable,
	input wire                  pwrite,
	input wire [31:0]           paddr,
	input wire [31:0]           pwdata,
	input wire                  pready,
	input wire                  pslverr,
	input wire [31:0]           prdata,
	input wire                  addrError,
	input wire                  nmiRequest,
	input wire                  moduleStop,
	input wire [`DMACM_NCH-1:0] reqN,
	input wire [`DMACM_NCH-1:0] ackN,
	input wire [`DMACM_NCH-1:0] endN,
	input wire                  irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr[31:6] != 0 |-> pslverr)
		else $error("unmapped access without slave error");
	a_reset_idle: assert property (disable iff (1'b0) rst |=> ackN == 4'hF && endN == 4'hF && !irq)
		else $error("outputs busy after reset");
	a_ack_two: assert property ($fell(ackN[0]) |=> !ackN[0] ##1 ackN[0])
		else $error("ack strobe not two cycles");
	a_end_two: assert property ($fell(endN[0]) |=> !endN[0] ##1 endN[0])
		else $error("end strobe not two cycles");
	a_rsv_zero: assert property (psel && !penable && !pwrite && paddr < 32'h10 |=>
		(prdata & 32'h0374_0000) == 0) else $error("reserved mode bits not zero");
	a_system_error_flag_ch0: assert property (psel && !penable && !pwrite && paddr[31:4] == 0
		&& paddr[3:2] != 0 |=> !prdata[19]) else $error("error flag outside channel 0");
	a_err_stops: assert property (addrError || nmiRequest |=> ##2 ackN == 4'hF)
		else $error("transfer runs on after error");
endmodule // dmacm_props
bind dmacm_top dmacm_props dmacm_props_i (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .addrError(addrError), .nmiRequest(nmiRequest),
	.moduleStop(moduleStop), .reqN(reqN), .ackN(ackN), .endN(endN), .irq(irq));

// [bench/dmacm_periph.sv]
// Purpose: external requester on channel 0, counts strobes
// Assumes: requests toggle so edge mode sees falling edges
// Notes:   slow stretches the request period to eight cycles; hold keeps it low
`timescale 1ns/1ps
module dmacm_periph (
	input  wire       clock,
	input  wire       rst,
	input  wire       go,
	input  wire       slow,
	input  wire       hold,
	input  wire [3:0] ackN,
	input  wire [3:0] endN,
	output wire [3:0] reqN,
	output int        ackCnt_r,
	output int        endCnt_r
);
	logic [2:0] ph_r;
	logic       ackQ_r;
	logic       endQ_r;
	// toggling keeps a fresh falling edge coming for edge mode
	assign reqN = {3'h7, !(go && (hold || (slow ? ph_r[2] : ph_r[0])))};
	always @(posedge clock) begin
		ph_r <= rst ? 3'h0 : ph_r + 3'h1;
		ackQ_r <= ackN[0];
		endQ_r <= endN[0];
		if (rst) begin
			ackCnt_r <= 0;
			endCnt_r <= 0;
		end else begin
			ackCnt_r <= ackCnt_r + (ackQ_r && !ackN[0]);
			endCnt_r <= endCnt_r + (endQ_r && !endN[0]);
		end
	end
endmodule // dmacm_periph

// [bench/dma_channel_mode_control_tb_top.sv]
// Purpose: self-checking bench for channel mode control
// Assumes: APB answers when pready is high
// Notes:   reads queue expected data, a monitor compares
`timescale 1ns/1ps
module dma_channel_mode_control_tb_top;
	logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, rnd;
	logic        addrError = 0, nmiRequest = 0, moduleStop = 0, go = 0, slow = 0, hold = 0;
	wire         pready, pslverr, irq;
	wire [31:0]  prdata;
	wire [3:0]   reqN, ackN, endN;
	int          ackCnt, endCnt, a0, e0, n, err_count = 0, num_checks = 0, seed = 90;
	logic [31:0] expQ[$];
	logic [31:0] md[6] = '{0, 32'h4000_0000, 32'h2000_0000, 0, 32'h4800_0000, 32'h0C00_0000};
	bit          sg[6] = '{1, 1, 1, 0, 0, 1};
	int          ea[6] = '{2, 0, 2, 0, 0, 2};
	int          ee[6] = '{1, 1, 0, 1, 1, 1};
	always #2.5 clock = ~clock;
	dmacm_top dmacm_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .addrError(addrError), .nmiRequest(nmiRequest),
		.moduleStop(moduleStop), .reqN(reqN), .ackN(ackN), .endN(endN), .irq(irq));
	dmacm_periph dmacm_periph_i (.clock(clock), .rst(rst), .go(go), .slow(slow), .hold(hold),
		.ackN(ackN), .endN(endN), .reqN(reqN), .ackCnt_r(ackCnt), .endCnt_r(endCnt));
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// request held until pready is seen high at an edge
	task apb(logic w, logic [31:0] a, logic [31:0] d, logic [31:0] exp);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		if (!w) expQ.push_back(exp);
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task wr(logic [31:0] a, logic [31:0] d); apb(1, a, d, 0); endtask
	task rd(logic [31:0] a, logic [31:0] exp); apb(0, a, 0, exp); endtask
	always @(posedge clock)
		if (psel && penable && !pwrite && pready) chk("prdata", prdata, expQ.pop_front());
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		test_done;
	end
	initial begin
		repeat (3) @(posedge clock);
		rst <= 0;
		for (int i = 0; i < 11; i++) rd(i * 4, 0);
		rd(32'h40, 0);
		wr(4, 32'h6FFF_FFFF);
		rd(4, 32'h6C00_0000);
		rnd = $random(seed) & 32'h6FFF_FFFF;
		wr(8, rnd);
		rd(8, rnd & 32'h6C00_0000);
		wr(4, 0);
		wr(8, 0);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			wr(32'h28, {31'h0, sg[i]});
			wr(32'h10, 2);
			wr(32'h24, 1);
			a0 = ackCnt;
			e0 = endCnt;
			slow <= i[0];
			wr(0, md[i] | 32'h8000_0000);
			go <= 1;
			for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clock);
			chk("irqSeen", irq, 1);
			go <= 0;
			chk("ackCount", ackCnt - a0, ea[i]);
			chk("endCount", endCnt - e0, ee[i]);
			rd(32'h20, 1);
			rd(0, md[i]);
			wr(32'h20, 32'h1F);
		end
		// edge mode with the request held low: no second falling edge, one unit only
		a0 = ackCnt;
		wr(32'h10, 2);
		wr(0, 32'h8800_0000);
		hold <= 1;
		go <= 1;
		repeat (20) @(posedge clock);
		chk("edgeHeld", ackCnt - a0, 1);
		rd(32'h10, 1);
		wr(0, 0);
		rd(0, 0);
		go <= 0;
		hold <= 0;
		$display("test transfers done");
		wr(0, 32'h8000_0000);
		rd(0, 32'h8000_0000);
		nmiRequest <= 1;
		@(posedge clock) nmiRequest <= 0;
		wr(0, 0);
		rd(0, 32'h0008_0000);
		rd(32'h20, 32'h10);
		wr(4, 32'h8000_0000);
		rd(4, 0);
		wr(0, 32'h0008_0000);
		rd(0, 32'h0008_0000);
		wr(0, 0);
		rd(0, 0);
		moduleStop <= 1;
		@(posedge clock) addrError <= 1;
		@(posedge clock) addrError <= 0;
		rd(0, 0);
		moduleStop <= 0;
		$display("test error flag done");
		test_done;
	end
endmodule // dma_channel_mode_control_tb_top
